// file: src/adc_digital_and_link_control_consts.vh
// register map, field positions and reset values of the digital and link control bank
`ifndef ADC_DIGITAL_AND_LINK_CONTROL_CONSTS_VH
`define ADC_DIGITAL_AND_LINK_CONTROL_CONSTS_VH
// page selects
`define PAGE_DIGITAL           16'h6800
`define PAGE_LINK              16'h6900
// register indices inside a page (byte address is four times the index)
`define IDX_INTERLEAVE_RESET   8'h00
`define IDX_INPUT_ZONE_SELECT  8'h42
`define IDX_INPUT_ZONE_OVR     8'h4e
`define IDX_OVR_LSB_ENABLE     8'hab
`define IDX_OVR_LSB_PLACEMENT  8'had
`define IDX_DIGITAL_RESET      8'hf7
`define IDX_LINK_ALIGN         8'h00
`define IDX_LINK_SYNC_LANE     8'h01
`define IDX_LINK_FRAMES        8'h06
// page select register of our own, in the upper word space
`define ADDR_PAGE_SEL          12'h400
// field positions
`define BIT_ZONE_OVERRANGE_LSB_ENABLE        7
`define BIT_MF_OVERRIDE        7
`define BIT_LANE_MODE_CHG_EN   6
`define BIT_DECIM4_SECOND      5
`define BIT_TEST_PATTERN_EN    4
`define BIT_LANE_ALIGN_INS     2
`define BIT_FRAME_ALIGN_INS    1
`define BIT_INIT_ALIGN_DIS     0
`define BIT_SYNC_FORCE_VAL     7
`define BIT_SYNC_FORCE_EN      6
`define BIT_SYNC_SEL           5
`define BIT_DECIM4_THIRD       3
// values
`define RST_REG                8'h00
`define DEFAULT_FRAMES_PER_MF  6'h05
`define OVR_PLACE_NONE         4'h0
`define OVR_PLACE_BIT0         4'h3
`define OVR_PLACE_BIT1         4'hc
`define OVR_PLACE_BOTH         4'hf
`define CHAR_K28_3             8'h7c
`define CHAR_K28_5             8'hbc
`define CHAR_K28_7             8'hfc
`endif

// file: src/adc_digital_and_link_control.v
// apb register bank steering the post-converter digital path and the link transmitter
//
// Functional notes
// - 3-bit zone code passed to interleaving engine
// - zone code used only when override bit set
// - overrange placement ignored unless enable bit set
// - placement code puts overrange on bit0/bit1/both
// - digital reset bit self-clears, spares interleave logic
// - five frames per multiframe unless override set
// - lane-mode writes accepted only when change enabled
// - test pattern enable only drives its own output, sample data not replaced
// - lane-align bit inserts K28.3 characters
// - frame-align bit inserts K28.7 characters
// - initial-alignment disable skips alignment sequence
// - sync force enable and value send K28.5
// - sync request from pair one or two
// - lane-mode codes 01/10/11 select 20x/40x/80x
// - digital page 6800h, link page 6900h
// - overridden frame count is field plus one
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "adc_digital_and_link_control_consts.vh"
`default_nettype none
module adc_digital_and_link_control #(
   parameter DATA_W = 16
) (
   input  wire              clk,
   input  wire              reset_n,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [11:0]       paddr,
   input  wire [31:0]       pwdata,
   output wire              pready,
   output reg  [31:0]       prdata,
   output wire              pslverr,
   input  wire              sync_request_pair_one,
   input  wire              sync_request_pair_two,
   input  wire [DATA_W-1:0] sample_in,
   input  wire              overrange_flag,
   output reg  [DATA_W-1:0] sample_out,
   output reg               interleave_engine_reset,
   output reg  [2:0]        zone_to_engine,
   output reg               zone_override_active,
   output reg               digital_block_reset,
   output reg  [5:0]        frames_per_multiframe,
   output reg  [1:0]        lane_rate_mode,
   output reg               transport_test_pattern_enable,
   output reg               lane_align_insert,
   output reg               frame_align_insert,
   output reg               initial_alignment_disable,
   output reg               sync_force_active,
   output reg  [7:0]        sync_force_char,
   output reg               sync_request_sel,
   output reg               decim4_enable_second,
   output reg               decim4_enable_third
);

   // ************************************************************
   // register storage
   // ************************************************************
   reg [15:0] page_ff;
   reg        interleave_engine_reset_ff;
   reg [2:0]  zone_ff;
   reg        zone_ovr_ff;
   reg        overrange_lsb_enable_ff;
   reg [3:0]  ovr_place_ff;
   reg        digital_block_reset_ff;
   reg [7:0]  link_align_ff;
   reg [7:0]  link_sync_ff;
   reg [4:0]  frames_ff;

   wire       wr_en;
   wire       rd_en;
   wire       is_page;
   wire [7:0] idx;
   wire       pg_dig;
   wire       pg_link;
   reg        hit;
   reg  [7:0] rd_byte;

   // apb decode, single-cycle access phase
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign is_page = (paddr == `ADDR_PAGE_SEL);
   assign idx     = paddr[9:2];
   assign pg_dig  = (page_ff == `PAGE_DIGITAL) & ~paddr[10] & (paddr[1:0] == 2'b00);
   assign pg_link = (page_ff == `PAGE_LINK) & ~paddr[10] & (paddr[1:0] == 2'b00);

   // read mux, unmapped reads return zero
   always @* begin
      hit     = 1'b1;
      rd_byte = `RST_REG;
      if (pg_dig && idx == `IDX_INTERLEAVE_RESET) begin
         rd_byte = {7'h00, interleave_engine_reset_ff};
      end else if (pg_dig && idx == `IDX_INPUT_ZONE_SELECT) begin
         rd_byte = {5'h00, zone_ff};
      end else if (pg_dig && idx == `IDX_INPUT_ZONE_OVR) begin
         rd_byte = {zone_ovr_ff, 7'h00};
      end else if (pg_dig && idx == `IDX_OVR_LSB_ENABLE) begin
         rd_byte = {7'h00, overrange_lsb_enable_ff};
      end else if (pg_dig && idx == `IDX_OVR_LSB_PLACEMENT) begin
         rd_byte = {4'h0, ovr_place_ff};
      end else if (pg_dig && idx == `IDX_DIGITAL_RESET) begin
         rd_byte = {7'h00, digital_block_reset_ff};
      end else if (pg_link && idx == `IDX_LINK_ALIGN) begin
         rd_byte = link_align_ff;
      end else if (pg_link && idx == `IDX_LINK_SYNC_LANE) begin
         rd_byte = link_sync_ff;
      end else if (pg_link && idx == `IDX_LINK_FRAMES) begin
         rd_byte = {3'h0, frames_ff};
      end else begin
         hit = 1'b0;
      end
   end

   // ************************************************************
   // register writes
   // ************************************************************
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         page_ff       <= 16'h0000;
         interleave_engine_reset_ff   <= 1'b0;
         zone_ff       <= 3'h0;
         zone_ovr_ff   <= 1'b0;
         overrange_lsb_enable_ff     <= 1'b0;
         ovr_place_ff  <= 4'h0;
         digital_block_reset_ff  <= 1'b0;
         link_align_ff <= `RST_REG;
         link_sync_ff  <= `RST_REG;
         frames_ff     <= 5'h00;
      end else begin
         // digital reset lasts one cycle then clears itself
         digital_block_reset_ff <= 1'b0;
         if (wr_en && is_page) begin
            page_ff <= pwdata[15:0];
         end
         if (wr_en && pg_dig) begin
            case (idx)
               `IDX_INTERLEAVE_RESET:  interleave_engine_reset_ff  <= pwdata[0];
               `IDX_INPUT_ZONE_SELECT: zone_ff      <= pwdata[2:0];
               `IDX_INPUT_ZONE_OVR:    zone_ovr_ff  <= pwdata[`BIT_ZONE_OVERRANGE_LSB_ENABLE];
               `IDX_OVR_LSB_ENABLE:    overrange_lsb_enable_ff    <= pwdata[0];
               `IDX_OVR_LSB_PLACEMENT: ovr_place_ff <= pwdata[3:0];
               `IDX_DIGITAL_RESET:     digital_block_reset_ff <= pwdata[0];
               default: ;
            endcase
         end
         if (wr_en && pg_link) begin
            case (idx)
               `IDX_LINK_ALIGN: link_align_ff <= {pwdata[7:4], 1'b0, pwdata[2:0]};
               `IDX_LINK_SYNC_LANE: begin
                  link_sync_ff[7:2] <= {pwdata[7:5], 1'b0, pwdata[3], 1'b0};
                  // lane mode only moves while change is enabled
                  if (link_align_ff[`BIT_LANE_MODE_CHG_EN]) begin
                     link_sync_ff[1:0] <= pwdata[1:0];
                  end
               end
               `IDX_LINK_FRAMES: frames_ff <= pwdata[4:0];
               default: ;
            endcase
         end
      end
   end

   // read data register
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         prdata <= is_page ? {16'h0000, page_ff} : (hit ? {24'h000000, rd_byte} : 32'h00000000);
      end
   end

   // ************************************************************
   // control outputs
   // ************************************************************
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         interleave_engine_reset       <= 1'b0;
         zone_to_engine                <= 3'h0;
         zone_override_active          <= 1'b0;
         digital_block_reset           <= 1'b0;
         frames_per_multiframe         <= `DEFAULT_FRAMES_PER_MF;
         lane_rate_mode                <= 2'b00;
         transport_test_pattern_enable <= 1'b0;
         lane_align_insert             <= 1'b0;
         frame_align_insert            <= 1'b0;
         initial_alignment_disable     <= 1'b0;
         sync_force_active             <= 1'b0;
         sync_force_char               <= 8'h00;
         sync_request_sel              <= 1'b1;
         decim4_enable_second          <= 1'b0;
         decim4_enable_third           <= 1'b0;
      end else begin
         interleave_engine_reset <= interleave_engine_reset_ff;
         zone_override_active    <= zone_ovr_ff;
         zone_to_engine          <= zone_ovr_ff ? zone_ff : 3'h0;
         digital_block_reset     <= digital_block_reset_ff;
         if (link_align_ff[`BIT_MF_OVERRIDE]) begin
            frames_per_multiframe <= {1'b0, frames_ff} + 6'h01;
         end else begin
            frames_per_multiframe <= `DEFAULT_FRAMES_PER_MF;
         end
         lane_rate_mode                <= link_sync_ff[1:0];
         transport_test_pattern_enable <= link_align_ff[`BIT_TEST_PATTERN_EN];
         lane_align_insert             <= link_align_ff[`BIT_LANE_ALIGN_INS];
         frame_align_insert            <= link_align_ff[`BIT_FRAME_ALIGN_INS];
         initial_alignment_disable     <= link_align_ff[`BIT_INIT_ALIGN_DIS];
         sync_force_active <= link_sync_ff[`BIT_SYNC_FORCE_EN] &
                              link_sync_ff[`BIT_SYNC_FORCE_VAL];
         // chosen request, active low from the receiver
         sync_request_sel <= link_sync_ff[`BIT_SYNC_SEL] ?
                             sync_request_pair_two : sync_request_pair_one;
         decim4_enable_second <= link_align_ff[`BIT_DECIM4_SECOND];
         decim4_enable_third  <= link_sync_ff[`BIT_DECIM4_THIRD];
         // character code the framer sends in place of data
         if (link_sync_ff[`BIT_SYNC_FORCE_EN] & link_sync_ff[`BIT_SYNC_FORCE_VAL]) begin
            sync_force_char <= `CHAR_K28_5;
         end else if (link_align_ff[`BIT_LANE_ALIGN_INS]) begin
            sync_force_char <= `CHAR_K28_3;
         end else if (link_align_ff[`BIT_FRAME_ALIGN_INS]) begin
            sync_force_char <= `CHAR_K28_7;
         end else begin
            sync_force_char <= 8'h00;
         end
      end
   end

   // ************************************************************
   // overrange on the two output lsbs
   // ************************************************************
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sample_out <= {DATA_W{1'b0}};
      end else if (digital_block_reset_ff) begin
         sample_out <= {DATA_W{1'b0}};
      end else begin
         sample_out <= sample_in;
         if (overrange_lsb_enable_ff) begin
            case (ovr_place_ff)
               `OVR_PLACE_BIT0: sample_out[0] <= overrange_flag;
               `OVR_PLACE_BIT1: sample_out[1] <= overrange_flag;
               `OVR_PLACE_BOTH: sample_out[1:0] <= {2{overrange_flag}};
               default: ;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// file: test/link_rx_model.sv
// model of the serial link receiver that raises the two sync requests
`timescale 1ns/10ps
`default_nettype none
module link_rx_model (
   input  wire logic clk,
   input  wire logic want_one,
   input  wire logic want_two,
   output var  logic sync_request_pair_one,
   output var  logic sync_request_pair_two
);
   // idle high: no request before the first edge
   initial {sync_request_pair_one, sync_request_pair_two} = 2'b11;
   // requests are active low and move just after a rising edge
   always @(posedge clk) begin
      sync_request_pair_one <= !want_one;
      sync_request_pair_two <= !want_two;
   end
endmodule
`default_nettype wire

// file: test/adc_digital_and_link_control_properties.sv
// port checker for the digital and link control bank
`timescale 1ns/10ps
`default_nettype none
module ctl_properties #(parameter DATA_W = 16) (
   input wire logic              clk, reset_n, psel, penable, pwrite,
   input wire logic              digital_block_reset, zone_override_active, sync_force_active,
   input wire logic              sync_request_sel, sync_request_pair_one, sync_request_pair_two,
   input wire logic [DATA_W-1:0] sample_in, sample_out,
   input wire logic [2:0]        zone_to_engine,
   input wire logic [5:0]        frames_per_multiframe,
   input wire logic [7:0]        sync_force_char
);
   // ****************
   // write taken at an edge
   // ****************
   wire logic wr = psel & penable & pwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   zone_gate_a: assert property (!zone_override_active |-> zone_to_engine == 3'h0)
      else $error("zone passed without override");
   zone_cause_a: assert property ($changed(zone_to_engine) |-> $past(wr, 2))
      else $error("zone moved without a write");
   frames_range_a: assert property (frames_per_multiframe inside {[1:32]})
      else $error("frame count out of range");
   frames_cause_a: assert property ($changed(frames_per_multiframe) |-> $past(wr, 2))
      else $error("frame count moved without a write");
   dig_pulse_a: assert property (digital_block_reset |=> !digital_block_reset)
      else $error("digital reset not self clearing");
   dig_cause_a: assert property (digital_block_reset |-> $past(wr, 2) || $past(wr, 3))
      else $error("digital reset without a write");
   sync_pick_a: assert property ($past(sync_request_pair_one) == $past(sync_request_pair_two)
      |-> sync_request_sel == $past(sync_request_pair_one)) else $error("sync request lost");
   force_char_a: assert property (sync_force_active |-> sync_force_char == 8'hbc)
      else $error("forced character wrong");
   ovr_pass_a: assert property ($past(reset_n) && !$past(digital_block_reset) &&
      !digital_block_reset |-> sample_out[DATA_W-1:2] == $past(sample_in[DATA_W-1:2]))
      else $error("sample upper bits altered");
   cover property (digital_block_reset);
   cover property (sync_force_active);
   cover property (zone_override_active && zone_to_engine != 3'h0);
endmodule
bind adc_digital_and_link_control ctl_properties #(.DATA_W(DATA_W)) i_props (.*);
`default_nettype wire

// file: test/adc_digital_and_link_control_tb.sv
// self-checking bench for the digital and link control bank
`timescale 1ns/10ps
`include "adc_digital_and_link_control_consts.vh"
`default_nettype none
module adc_digital_and_link_control_tb;
   localparam logic [15:0] DP = `PAGE_DIGITAL;
   localparam logic [15:0] LP = `PAGE_LINK;
   logic clk, reset_n, psel, penable, pwrite, overrange_flag, want_one, want_two;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [15:0] sample_in;
   wire logic pready, pslverr, interleave_engine_reset, zone_override_active;
   wire logic digital_block_reset, transport_test_pattern_enable, lane_align_insert;
   wire logic frame_align_insert, initial_alignment_disable, sync_force_active;
   wire logic sync_request_sel, decim4_enable_second, decim4_enable_third;
   wire logic sync_request_pair_one, sync_request_pair_two;
   wire logic [31:0] prdata;
   wire logic [15:0] sample_out;
   wire logic [2:0] zone_to_engine;
   wire logic [5:0] frames_per_multiframe;
   wire logic [1:0] lane_rate_mode;
   wire logic [7:0] sync_force_char;
   wire logic [3:0] flags = {transport_test_pattern_enable, lane_align_insert,
                             frame_align_insert, initial_alignment_disable};
   int failures, check_count;
   adc_digital_and_link_control i_dut (.*);
   link_rx_model i_rx (.*);
   // ****************
   // shared tasks
   // ****************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic put(input logic [15:0] pg, input logic [7:0] ix, input logic [7:0] d);
      bus(1'b1, `ADDR_PAGE_SEL, {16'h0, pg});
      bus(1'b1, {2'b00, ix, 2'b00}, {24'h0, d});
      repeat (2) @(negedge clk);
   endtask
   task automatic get(input logic [15:0] pg, input logic [7:0] ix, input logic [7:0] e);
      bus(1'b1, `ADDR_PAGE_SEL, {16'h0, pg});
      bus(1'b0, {2'b00, ix, 2'b00}, 32'h0);
      @(negedge clk);
      chk("prdata", {24'h0, e}, prdata);
      chk("pslverr", 0, pslverr);
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_digital_page;
      put(DP, 8'h00, 8'h01);
      chk("interleave_engine_reset", 1, interleave_engine_reset);
      get(DP, 8'h00, 8'h01);
      get(LP, 8'h00, 8'h00);
      put(DP, 8'hf7, 8'h01);
      get(DP, 8'hf7, 8'h00);
      chk("interleave_engine_reset", 1, interleave_engine_reset);
      put(DP, 8'h00, 8'h00);
      chk("interleave_engine_reset", 0, interleave_engine_reset);
      get(DP, 8'hff, 8'h00);
   endtask
   task automatic t_zone;
      put(DP, 8'h42, 8'h05);
      chk("zone", 0, zone_to_engine);
      put(DP, 8'h4e, 8'h80);
      chk("zone_ovr", 1, zone_override_active);
      for (int i = 0; i < 8; i++) begin
         put(DP, 8'h42, 8'(i));
         chk("zone", i, zone_to_engine);
      end
   endtask
   task automatic t_overrange;
      logic [3:0] code [4] = '{4'h0, 4'h3, 4'hc, 4'hf};
      put(DP, 8'had, 8'h03);
      chk("sample", 16'h1234, sample_out);
      put(DP, 8'hab, 8'h01);
      put(DP, 8'had, 8'h00);
      chk("sample_hi", 16'h1234 >> 2, sample_out[15:2]);
      for (int i = 1; i < 4; i++) begin
         put(DP, 8'had, {4'h0, code[i]});
         chk("sample", 32'h1234 | i, sample_out);
      end
   endtask
   task automatic t_link;
      put(LP, 8'h06, 8'h0f);
      chk("frames", 5, frames_per_multiframe);
      put(LP, 8'h00, 8'h80);
      chk("frames", 16, frames_per_multiframe);
      put(LP, 8'h01, 8'h03);
      chk("lane", 0, lane_rate_mode);
      put(LP, 8'h00, 8'h40);
      for (int m = 1; m < 4; m++) begin
         put(LP, 8'h01, 8'(m));
         chk("lane", m, lane_rate_mode);
      end
      put(LP, 8'h00, 8'h17);
      chk("flags", 4'hf, flags);
      chk("char", `CHAR_K28_3, sync_force_char);
      put(LP, 8'h00, 8'h02);
      chk("char", `CHAR_K28_7, sync_force_char);
      chk("flags", 4'h2, flags);
   endtask
   task automatic t_sync;
      @(posedge clk);
      want_one <= 1'b1;
      put(LP, 8'h01, 8'h80);
      chk("force", 0, sync_force_active);
      chk("sync", 0, sync_request_sel);
      put(LP, 8'h01, 8'he0);
      chk("force", 1, sync_force_active);
      chk("char", `CHAR_K28_5, sync_force_char);
      chk("sync", 1, sync_request_sel);
      put(LP, 8'h00, 8'h20);
      put(LP, 8'h01, 8'h08);
      chk("decim4", 2'b11, {decim4_enable_second, decim4_enable_third});
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      final_report;
   end
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, want_one, want_two} = '0;
      sample_in = 16'h1234;
      overrange_flag = 1'b1;
      reset_n = 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      chk("frames", 5, frames_per_multiframe);
      t_digital_page;
      t_zone;
      t_overrange;
      t_link;
      t_sync;
      final_report;
   end
endmodule
`default_nettype wire
